// file: src/ibaf_pkg.sv
`default_nettype none
package ibaf_pkg;

   // ==========================================================
   // register indices on the plain register port
   // ==========================================================
   localparam logic [7:0] REG_CTRL       = 8'h00;
   localparam logic [7:0] REG_STATUS     = 8'h01;
   localparam logic [7:0] REG_IBASE_LO   = 8'h02;
   localparam logic [7:0] REG_IBASE_HI   = 8'h03;
   localparam logic [7:0] REG_MODE       = 8'h04;
   localparam logic [7:0] REG_RX_LEN     = 8'h05;
   localparam logic [7:0] REG_TX_LEN     = 8'h06;
   localparam logic [7:0] REG_STA0       = 8'h07;
   localparam logic [7:0] REG_STA2       = 8'h09;
   localparam logic [7:0] REG_HASH0      = 8'h0A;
   localparam logic [7:0] REG_HASH3      = 8'h0D;
   localparam logic [7:0] REG_RX_BASE_LO = 8'h0E;
   localparam logic [7:0] REG_RX_BASE_HI = 8'h0F;
   localparam logic [7:0] REG_TX_BASE_LO = 8'h10;
   localparam logic [7:0] REG_TX_BASE_HI = 8'h11;

   // ==========================================================
   // field positions
   // ==========================================================
   localparam int CTRL_START_BIT    = 0;
   localparam int STAT_DONE_BIT     = 0;
   localparam int STAT_BUSY_BIT     = 1;
   localparam int MODE_PROM_BIT     = 15;
   localparam int MODE_BCAST_DIS_BIT = 14;
   localparam int MODE_TX_CKSUM_DIS_BIT = 3;
   localparam int LEN_CODE_MSB      = 15;
   localparam int LEN_CODE_LSB      = 13;

   // ==========================================================
   // initialization block word order
   // ==========================================================
   localparam logic [3:0] WORD_MODE   = 4'h0;
   localparam logic [3:0] WORD_STA0   = 4'h1;
   localparam logic [3:0] WORD_STA2   = 4'h3;
   localparam logic [3:0] WORD_HASH0  = 4'h4;
   localparam logic [3:0] WORD_HASH3  = 4'h7;
   localparam logic [3:0] WORD_RX_LO  = 4'h8;
   localparam logic [3:0] WORD_RX_HI  = 4'h9;
   localparam logic [3:0] WORD_TX_LO  = 4'hA;
   localparam logic [3:0] WORD_TX_HI  = 4'hB;
   localparam logic [23:0] WORD_STEP  = 24'h000002;

   // ==========================================================
   // reset values and hash constants
   // ==========================================================
   localparam logic [15:0] MODE_RST     = 16'h0000;
   localparam logic [15:0] RING_LEN_RST = 16'h0000;
   localparam logic [23:0] IBASE_RST    = 24'h000000;
   localparam logic [15:0] RING_LEN_ONE = 16'h0001;
   localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY     = 32'h04C11DB7;
   localparam int HASH_MSB = 31;
   localparam int HASH_LSB = 26;

   // ==========================================================
   // types
   // ==========================================================
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_DONE  = 2'b10
   } ibaf_state_e;

   typedef logic [5:0] ibaf_hash_t;

   typedef struct packed {
      logic        req;
      logic [23:0] addr;
   } ibaf_mem_req_s;

   typedef struct packed {
      logic valid;
      logic accept;
   } ibaf_filt_res_s;

   typedef struct packed {
      ibaf_state_e    state;
      logic [3:0]     idx;
      logic [23:0]    init_base;
      ibaf_mem_req_s  mem;
      logic [15:0]    mode;
      logic [47:0]    station;
      logic [63:0]    hash_mask;
      logic [23:0]    rx_base;
      logic [23:0]    tx_base;
      logic [2:0]     rx_code;
      logic [2:0]     tx_code;
      logic [15:0]    rx_len;
      logic [15:0]    tx_len;
      logic           init_done;
      logic [15:0]    rdata;
      logic [47:0]    da_q;
      logic           da_valid;
      ibaf_filt_res_s filt;
   } ibaf_top_state_s;

endpackage : ibaf_pkg
`default_nettype wire

// file: src/ibaf_crc_hash.sv
`timescale 1ns/100ps
`default_nettype none
module ibaf_crc_hash (
   input  wire logic              clk_in,
   input  wire logic              reset_n_in,
   input  wire logic [47:0]       addr_in,
   output var  ibaf_pkg::ibaf_hash_t hash_out
);

   // ==========================================================
   // serial crc unrolled over the 48 address bits, wire order
   // ==========================================================
   logic [31:0]          chain [0:48];
   ibaf_pkg::ibaf_hash_t next_hash;

   assign chain[0] = ibaf_pkg::CRC_INIT;

   generate
      for (genvar g = 0; g < 48; g++) begin : g_bit
         logic fb;
         assign fb           = chain[g][31] ^ addr_in[g];
         assign chain[g + 1] = {chain[g][30:0], 1'b0} ^ (fb ? ibaf_pkg::CRC_POLY : 32'h00000000);
      end
   endgenerate

   always_comb begin
      next_hash = chain[48][ibaf_pkg::HASH_MSB:ibaf_pkg::HASH_LSB];
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         hash_out <= '0;
      end else begin
         hash_out <= next_hash;
      end
   end

endmodule : ibaf_crc_hash
`default_nettype wire

// file: src/ibaf_loader.sv
// Behaviour
// - ring length code in bits 15:13
// - code n gives two to n entries
// - software-written ring lengths override decoded ones
// - first wire bit selects logical or physical
// - crc top six bits pick mask bit
// - empty mask rejects non-broadcast logical addresses unless promiscuous
// - broadcast bypasses mask, accepted unless disabled
// - disabled broadcast accepted only when promiscuous
// - hold 48-bit station address for compare
// - station bit 0 is first wire bit
// - address byte n fills bits 8n+7:8n
// - init copies mode word into mode register
`timescale 1ns/100ps
`default_nettype none
module ibaf_loader (
   input  wire logic                     CLK_IN,
   input  wire logic                     RESET_N_IN,
   input  wire logic [7:0]               REG_ADDR_IN,
   input  wire logic [15:0]              REG_WDATA_IN,
   input  wire logic                     REG_WR_IN,
   input  wire logic                     REG_RD_IN,
   output var  logic [15:0]              REG_RDATA_OUT,
   output var  ibaf_pkg::ibaf_mem_req_s  MEM_REQ_OUT,
   input  wire logic                     MEM_ACK_IN,
   input  wire logic [15:0]              MEM_RDATA_IN,
   input  wire logic                     RX_DA_VALID_IN,
   input  wire logic [47:0]              RX_DA_IN,
   output var  ibaf_pkg::ibaf_filt_res_s FILT_OUT,
   output var  logic [15:0]              MODE_OUT,
   output var  logic [23:0]              RX_RING_BASE_OUT,
   output var  logic [23:0]              TX_RING_BASE_OUT,
   output var  logic [15:0]              RX_RING_LEN_OUT,
   output var  logic [15:0]              TX_RING_LEN_OUT,
   output var  logic                     INIT_DONE_OUT
);

   ibaf_pkg::ibaf_top_state_s st;
   ibaf_pkg::ibaf_top_state_s next_st;
   ibaf_pkg::ibaf_hash_t      hash;
   logic                      wr_start;
   logic                      prom;
   logic                      bcast_dis;
   logic                      is_bcast;
   logic                      is_logical;

   // ==========================================================
   // hash unit, result lines up with the captured address
   // ==========================================================
   ibaf_crc_hash u_hash (
      .clk_in     (CLK_IN),
      .reset_n_in (RESET_N_IN),
      .addr_in    (RX_DA_IN),
      .hash_out   (hash)
   );

   assign wr_start   = REG_WR_IN && (REG_ADDR_IN == ibaf_pkg::REG_CTRL) &&
                       REG_WDATA_IN[ibaf_pkg::CTRL_START_BIT];
   assign prom       = st.mode[ibaf_pkg::MODE_PROM_BIT];
   assign bcast_dis  = st.mode[ibaf_pkg::MODE_BCAST_DIS_BIT];
   assign is_bcast   = &st.da_q;
   assign is_logical = st.da_q[0];

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      next_st = st;

      // ---------------- initialization block fetch
      case (st.state)
         ibaf_pkg::ST_IDLE, ibaf_pkg::ST_DONE: begin
            if (wr_start) begin
               next_st.state     = ibaf_pkg::ST_FETCH;
               next_st.idx       = ibaf_pkg::WORD_MODE;
               next_st.init_done = 1'b0;
               next_st.mem.req   = 1'b1;
               next_st.mem.addr  = st.init_base;
            end
         end
         ibaf_pkg::ST_FETCH: begin
            if (MEM_ACK_IN) begin
               if (st.idx == ibaf_pkg::WORD_MODE) begin
                  next_st.mode = MEM_RDATA_IN;
               end else if (st.idx <= ibaf_pkg::WORD_STA2) begin
                  next_st.station[(int'(st.idx) - 1) * 16 +: 16] = MEM_RDATA_IN;
               end else if (st.idx <= ibaf_pkg::WORD_HASH3) begin
                  next_st.hash_mask[(int'(st.idx) - 4) * 16 +: 16] = MEM_RDATA_IN;
               end else if (st.idx == ibaf_pkg::WORD_RX_LO) begin
                  next_st.rx_base[15:0] = MEM_RDATA_IN;
               end else if (st.idx == ibaf_pkg::WORD_RX_HI) begin
                  next_st.rx_base[23:16] = MEM_RDATA_IN[7:0];
                  next_st.rx_code = MEM_RDATA_IN[ibaf_pkg::LEN_CODE_MSB:ibaf_pkg::LEN_CODE_LSB];
               end else if (st.idx == ibaf_pkg::WORD_TX_LO) begin
                  next_st.tx_base[15:0] = MEM_RDATA_IN;
               end else begin
                  next_st.tx_base[23:16] = MEM_RDATA_IN[7:0];
                  next_st.tx_code = MEM_RDATA_IN[ibaf_pkg::LEN_CODE_MSB:ibaf_pkg::LEN_CODE_LSB];
               end
               if (st.idx == ibaf_pkg::WORD_TX_HI) begin
                  next_st.state     = ibaf_pkg::ST_DONE;
                  next_st.init_done = 1'b1;
                  next_st.mem.req   = 1'b0;
                  next_st.rx_len = ibaf_pkg::RING_LEN_ONE << st.rx_code;
                  next_st.tx_len = ibaf_pkg::RING_LEN_ONE <<
                                   MEM_RDATA_IN[ibaf_pkg::LEN_CODE_MSB:ibaf_pkg::LEN_CODE_LSB];
               end else begin
                  next_st.idx      = st.idx + 4'h1;
                  next_st.mem.addr = st.mem.addr + ibaf_pkg::WORD_STEP;
               end
            end
         end
         default: begin
            next_st.state   = ibaf_pkg::ST_IDLE;
            next_st.mem.req = 1'b0;
         end
      endcase

      // ---------------- register writes
      if (REG_WR_IN) begin
         if (REG_ADDR_IN == ibaf_pkg::REG_IBASE_LO) begin
            next_st.init_base[15:0] = REG_WDATA_IN;
         end else if (REG_ADDR_IN == ibaf_pkg::REG_IBASE_HI) begin
            next_st.init_base[23:16] = REG_WDATA_IN[7:0];
         end else if (REG_ADDR_IN == ibaf_pkg::REG_MODE) begin
            next_st.mode = REG_WDATA_IN;
         end else if (REG_ADDR_IN == ibaf_pkg::REG_RX_LEN) begin
            next_st.rx_len = REG_WDATA_IN;
         end else if (REG_ADDR_IN == ibaf_pkg::REG_TX_LEN) begin
            next_st.tx_len = REG_WDATA_IN;
         end
      end

      // ---------------- register reads, data stand one cycle
      next_st.rdata = 16'h0000;
      if (REG_RD_IN) begin
         if (REG_ADDR_IN == ibaf_pkg::REG_STATUS) begin
            next_st.rdata[ibaf_pkg::STAT_DONE_BIT] = st.init_done;
            next_st.rdata[ibaf_pkg::STAT_BUSY_BIT] = (st.state == ibaf_pkg::ST_FETCH);
         end else if (REG_ADDR_IN == ibaf_pkg::REG_IBASE_LO) begin
            next_st.rdata = st.init_base[15:0];
         end else if (REG_ADDR_IN == ibaf_pkg::REG_IBASE_HI) begin
            next_st.rdata = {8'h00, st.init_base[23:16]};
         end else if (REG_ADDR_IN == ibaf_pkg::REG_MODE) begin
            next_st.rdata = st.mode;
         end else if (REG_ADDR_IN == ibaf_pkg::REG_RX_LEN) begin
            next_st.rdata = st.rx_len;
         end else if (REG_ADDR_IN == ibaf_pkg::REG_TX_LEN) begin
            next_st.rdata = st.tx_len;
         end else if (REG_ADDR_IN >= ibaf_pkg::REG_STA0 && REG_ADDR_IN <= ibaf_pkg::REG_STA2) begin
            next_st.rdata = st.station[(int'(REG_ADDR_IN - ibaf_pkg::REG_STA0)) * 16 +: 16];
         end else if (REG_ADDR_IN >= ibaf_pkg::REG_HASH0 && REG_ADDR_IN <= ibaf_pkg::REG_HASH3) begin
            next_st.rdata = st.hash_mask[(int'(REG_ADDR_IN - ibaf_pkg::REG_HASH0)) * 16 +: 16];
         end else if (REG_ADDR_IN == ibaf_pkg::REG_RX_BASE_LO) begin
            next_st.rdata = st.rx_base[15:0];
         end else if (REG_ADDR_IN == ibaf_pkg::REG_RX_BASE_HI) begin
            next_st.rdata = {st.rx_code, 5'h00, st.rx_base[23:16]};
         end else if (REG_ADDR_IN == ibaf_pkg::REG_TX_BASE_LO) begin
            next_st.rdata = st.tx_base[15:0];
         end else if (REG_ADDR_IN == ibaf_pkg::REG_TX_BASE_HI) begin
            next_st.rdata = {st.tx_code, 5'h00, st.tx_base[23:16]};
         end
      end

      // ---------------- receive address filter, two cycles
      next_st.da_valid = RX_DA_VALID_IN;
      if (RX_DA_VALID_IN) begin
         next_st.da_q = RX_DA_IN;
      end
      next_st.filt.valid = st.da_valid;
      if (prom) begin
         next_st.filt.accept = 1'b1;
      end else if (is_bcast) begin
         next_st.filt.accept = !bcast_dis;
      end else if (is_logical) begin
         next_st.filt.accept = st.hash_mask[hash];
      end else begin
         next_st.filt.accept = (st.da_q == st.station);
      end
   end

   // ==========================================================
   // state register
   // ==========================================================
   always_ff @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         st           <= '0;
         st.state     <= ibaf_pkg::ST_IDLE;
         st.mode      <= ibaf_pkg::MODE_RST;
         st.init_base <= ibaf_pkg::IBASE_RST;
         st.rx_len    <= ibaf_pkg::RING_LEN_RST;
         st.tx_len    <= ibaf_pkg::RING_LEN_RST;
      end else begin
         st <= next_st;
      end
   end

   assign REG_RDATA_OUT    = st.rdata;
   assign MEM_REQ_OUT      = st.mem;
   assign FILT_OUT         = st.filt;
   assign MODE_OUT         = st.mode;
   assign RX_RING_BASE_OUT = st.rx_base;
   assign TX_RING_BASE_OUT = st.tx_base;
   assign RX_RING_LEN_OUT  = st.rx_len;
   assign TX_RING_LEN_OUT  = st.tx_len;
   assign INIT_DONE_OUT    = st.init_done;

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   property p_mode_copy;
      st.state == ibaf_pkg::ST_FETCH && MEM_ACK_IN && st.idx == ibaf_pkg::WORD_MODE && !REG_WR_IN
      |=> MODE_OUT == $past(MEM_RDATA_IN);
   endproperty
   a_mode_copy: assert property (p_mode_copy) else $error("mode word not copied");

   property p_len_decode;
      $rose(INIT_DONE_OUT) && !$past(REG_WR_IN)
      |-> RX_RING_LEN_OUT == (ibaf_pkg::RING_LEN_ONE << st.rx_code) &&
          TX_RING_LEN_OUT == (ibaf_pkg::RING_LEN_ONE << st.tx_code);
   endproperty
   a_len_decode: assert property (p_len_decode) else $error("ring length decode wrong");

   property p_rx_base_hi;
      st.state == ibaf_pkg::ST_FETCH && MEM_ACK_IN && st.idx == ibaf_pkg::WORD_RX_HI
      |=> RX_RING_BASE_OUT[23:16] == $past(MEM_RDATA_IN[7:0]) && st.rx_code == $past(MEM_RDATA_IN[15:13]);
   endproperty
   a_rx_base_hi: assert property (p_rx_base_hi) else $error("rx base high byte wrong");

   property p_sw_len;
      REG_WR_IN && REG_ADDR_IN == ibaf_pkg::REG_RX_LEN |=> RX_RING_LEN_OUT == $past(REG_WDATA_IN);
   endproperty
   a_sw_len: assert property (p_sw_len) else $error("rx ring length write lost");

   property p_physical;
      st.da_valid && !is_logical && !prom
      |=> FILT_OUT.valid && FILT_OUT.accept == ($past(st.da_q) == $past(st.station));
   endproperty
   a_physical: assert property (p_physical) else $error("physical match wrong");

   property p_hash_pick;
      st.da_valid && is_logical && !is_bcast && !prom
      |=> FILT_OUT.valid && FILT_OUT.accept == $past(st.hash_mask[hash]);
   endproperty
   a_hash_pick: assert property (p_hash_pick) else $error("hash mask select wrong");

   property p_empty_mask;
      st.da_valid && is_logical && !is_bcast && !prom && st.hash_mask == 64'h0000000000000000
      |=> !FILT_OUT.accept;
   endproperty
   a_empty_mask: assert property (p_empty_mask) else $error("empty mask accepted");

   property p_bcast_on;
      st.da_valid && is_bcast && !bcast_dis |=> FILT_OUT.valid ##0 FILT_OUT.accept;
   endproperty
   a_bcast_on: assert property (p_bcast_on) else $error("broadcast rejected");

   property p_bcast_off;
      st.da_valid && is_bcast && bcast_dis |=> FILT_OUT.accept == $past(prom);
   endproperty
   a_bcast_off: assert property (p_bcast_off) else $error("disabled broadcast wrong");

   property p_addr_step;
      st.state == ibaf_pkg::ST_FETCH && MEM_ACK_IN && st.idx != ibaf_pkg::WORD_TX_HI
      |=> MEM_REQ_OUT.req && MEM_REQ_OUT.addr == $past(MEM_REQ_OUT.addr) + ibaf_pkg::WORD_STEP;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("fetch address step wrong");

   property p_fetch_end;
      st.state == ibaf_pkg::ST_FETCH && MEM_ACK_IN && st.idx == ibaf_pkg::WORD_TX_HI
      |=> INIT_DONE_OUT && !MEM_REQ_OUT.req;
   endproperty
   a_fetch_end: assert property (p_fetch_end) else $error("fetch did not end");

endmodule : ibaf_loader
`default_nettype wire

// file: verif/ibaf_host_mem.sv
`timescale 1ns/100ps
`default_nettype none
module ibaf_host_mem (
   input  wire logic                    clk_in,
   input  wire logic                    reset_n_in,
   input  wire ibaf_pkg::ibaf_mem_req_s req_in,
   input  wire logic [3:0]              wait_in,
   output var  logic                    ack_out,
   output var  logic [15:0]             rdata_out
);
   logic [15:0] mem [0:255];
   logic [3:0]  cnt;

   initial rdata_out = 16'h5A5A;

   // ==========================================================
   // word fetch with programmable wait
   // ==========================================================
   // whole-word fetch
   always @(posedge clk_in) begin
      if (!reset_n_in || !req_in.req || ack_out) begin
         ack_out   <= 1'b0;
         cnt       <= 4'h0;
         rdata_out <= ~rdata_out;
      end else if (cnt == wait_in) begin
         ack_out   <= 1'b1;
         rdata_out <= mem[req_in.addr[8:1]];
      end else begin
         cnt       <= cnt + 4'h1;
         rdata_out <= ~rdata_out;
      end
   end
endmodule : ibaf_host_mem
`default_nettype wire

// file: verif/tb_init_block_address_filter.sv
`timescale 1ns/100ps
`default_nettype none
module tb_init_block_address_filter;
   logic                     clk   = 1'b0;
   logic                     rst_n = 1'b0;
   logic [7:0]               addr  = 8'h00;
   logic [15:0]              wdata = 16'h0000;
   logic                     wr    = 1'b0;
   logic                     rd    = 1'b0;
   logic                     da_v  = 1'b0;
   logic [47:0]              da    = 48'h000000000000;
   logic [3:0]               mwait = 4'h0;
   logic [15:0]              rdata, mdata, mode, rx_len, tx_len, mword;
   logic [23:0]              rx_base, tx_base, rxb, txb;
   logic                     mack, done;
   ibaf_pkg::ibaf_mem_req_s  mreq;
   ibaf_pkg::ibaf_filt_res_s filt;
   logic [47:0]              sta, rnd;
   logic [63:0]              mask;
   int                       mismatches  = 0;
   int                       check_count = 0;

   always #12.5 clk = ~clk;

   ibaf_loader ibaf_loader_i (.CLK_IN(clk), .RESET_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .MEM_REQ_OUT(mreq), .MEM_ACK_IN(mack),
      .MEM_RDATA_IN(mdata), .RX_DA_VALID_IN(da_v), .RX_DA_IN(da), .FILT_OUT(filt), .MODE_OUT(mode),
      .RX_RING_BASE_OUT(rx_base), .TX_RING_BASE_OUT(tx_base), .RX_RING_LEN_OUT(rx_len),
      .TX_RING_LEN_OUT(tx_len), .INIT_DONE_OUT(done));

   ibaf_host_mem ibaf_host_mem_i (.clk_in(clk), .reset_n_in(rst_n), .req_in(mreq), .wait_in(mwait),
      .ack_out(mack), .rdata_out(mdata));

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string msg);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp, msg);
   endtask : rd_chk

   function automatic logic [5:0] hash_of(input logic [47:0] a);
      logic [31:0] c;
      c = ibaf_pkg::CRC_INIT;
      for (int i = 0; i < 48; i++) begin
         c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i]) ? ibaf_pkg::CRC_POLY : 32'h00000000);
      end
      return c[31:26];
   endfunction : hash_of

   task automatic send(input logic [47:0] a);
      logic e;
      e = mword[15] ? 1'b1 : (&a) ? ~mword[14] : a[0] ? mask[hash_of(a)] : (a == sta);
      @(posedge clk);
      da_v <= 1'b1;
      da   <= a;
      @(posedge clk);
      da_v <= 1'b0;
      @(posedge clk);
      #1;
      chk(filt.valid, 1'b1, "filter result missing");
      chk(filt.accept, e, "filter decision");
   endtask : send

   task automatic init_run(input logic [2:0] code);
      rnd   = {16'($urandom()), $urandom()};
      mwait <= 4'(code);
      mword = {2'b00, rnd[13:4], 1'b1, rnd[2:0]};
      sta   = {rnd[47:1], 1'b0};
      mask  = (code == 3'h7) ? 64'h0 : {$urandom(), $urandom()};
      rxb   = {21'($urandom()), 3'b000};
      txb   = {21'($urandom()), 3'b000};
      ibaf_host_mem_i.mem[32] = mword;
      for (int i = 0; i < 3; i++) ibaf_host_mem_i.mem[33 + i] = sta[16 * i +: 16];
      for (int i = 0; i < 4; i++) ibaf_host_mem_i.mem[36 + i] = mask[16 * i +: 16];
      ibaf_host_mem_i.mem[40] = rxb[15:0];
      ibaf_host_mem_i.mem[41] = {code, 5'h00, rxb[23:16]};
      ibaf_host_mem_i.mem[42] = txb[15:0];
      ibaf_host_mem_i.mem[43] = {~code, 5'h00, txb[23:16]};
      reg_wr(ibaf_pkg::REG_IBASE_LO, 16'h0040);
      reg_wr(ibaf_pkg::REG_IBASE_HI, 16'h0000);
      reg_wr(ibaf_pkg::REG_CTRL, 16'h0001);
      if (code == 3'h3) begin
         reg_wr(ibaf_pkg::REG_IBASE_LO, 16'h0100);
         reg_wr(ibaf_pkg::REG_CTRL, 16'h0001);
         rd_chk(ibaf_pkg::REG_STATUS, 16'h0001 << ibaf_pkg::STAT_BUSY_BIT, "status busy");
      end
      for (int i = 0; i < 300; i++) begin
         @(posedge clk);
         #1;
         if (done === 1'b1) break;
      end
      chk(done, 1'b1, "init not done");
      chk(mode, mword, "mode copy");
      chk(rx_base, rxb, "rx ring base");
      chk(tx_base, txb, "tx ring base");
      chk(rx_len, 16'h0001 << code, "rx ring length");
      chk(tx_len, 16'h0001 << (3'h7 - code), "tx ring length");
      for (int i = 0; i < 3; i++) rd_chk(ibaf_pkg::REG_STA0 + 8'(i), sta[16 * i +: 16], "station");
      rd_chk(ibaf_pkg::REG_RX_BASE_HI, {code, 5'h00, rxb[23:16]}, "rx base high");
      rd_chk(ibaf_pkg::REG_STATUS, 16'h0001 << ibaf_pkg::STAT_DONE_BIT, "status done");
      for (int i = 0; i < 4; i++) rd_chk(ibaf_pkg::REG_HASH0 + 8'(i), mask[16 * i +: 16], "mask");
      for (int m = 0; m < 4; m++) begin
         mword[15:14] = 2'(m);
         reg_wr(ibaf_pkg::REG_MODE, mword);
         send(48'hFFFFFFFFFFFF);
         send(sta);
         send(sta ^ 48'h010000000000);
         for (int k = 0; k < 3; k++) send({16'($urandom()), $urandom()} | 48'h1);
      end
      $display("test init code %0d done", code);
   endtask : init_run

   initial begin
      #(25 * 40000);
      mismatches++;
      test_done();
   end

   initial begin
      void'($urandom(32'h630d3c3f));
      repeat (5) @(posedge clk);
      #1;
      chk({done, mreq.req, filt.valid, mode}, 19'h0, "reset outputs");
      @(posedge clk);
      rst_n <= 1'b1;
      for (int c = 0; c < 8; c++) init_run(3'(c));
      reg_wr(ibaf_pkg::REG_RX_LEN, 16'h0064);
      reg_wr(ibaf_pkg::REG_TX_LEN, 16'h0003);
      #1;
      chk(rx_len, 16'h0064, "rx length override");
      chk(tx_len, 16'h0003, "tx length override");
      rd_chk(ibaf_pkg::REG_TX_LEN, 16'h0003, "tx length read");
      rd_chk(8'h20, 16'h0000, "unmapped read");
      reg_wr(ibaf_pkg::REG_STA0, ~sta[15:0]);
      rd_chk(ibaf_pkg::REG_STA0, sta[15:0], "station read-only");
      $display("test registers done");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({done, mode, rx_len}, 33'h0, "second reset");
      $display("test reset done");
      test_done();
   end
endmodule : tb_init_block_address_filter
`default_nettype wire
